// >>> bdm_regfile.sv
// Banked data memory: pointer, bank storage, global storage and special-register routing.
`timescale 1ns/1ps
`default_nettype none
module bdm_regfile
  import bdm_pkg::*;
#(
  parameter logic [2:0] PORT_PRESENT = BDM_PORT_PRESENT_DEF
)
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_arst_n, // Asynchronous reset, active low
  input wire logic [4:0] i_reg_select_field, // Select field of the current instruction
  input wire logic i_rd_en, // Read request
  input wire logic i_wr_en, // Whole-byte write request
  input wire logic [7:0] i_wr_data, // Whole-byte write data
  input wire logic i_bit_en, // Single-bit write request
  input wire logic [2:0] i_bit_idx, // Bit position for a single-bit write
  input wire logic i_bit_val, // Value for a single-bit write
  input wire logic i_bank_sel_en, // Bank-select instruction
  input wire logic [2:0] i_bank_sel_bits, // Bank bits 7-5 from the opcode
  input wire logic i_option_extension_config_word_a, // Config_word_a bit, 0 allows accumulator mapping
  input wire logic i_counter_vs_accum_map, // Option bit, 0 maps accumulator at 01h
  input wire logic [7:0] i_accum, // Accumulator value
  input wire logic [7:0] i_sfr_rdata, // Read data of the selected special register
  output logic [7:0] o_rd_data, // Read data, one cycle after the request
  output logic o_rd_valid, // Read data valid
  output logic [7:0] o_file_select_pointer, // Pointer value
  output logic [3:0] o_sfr_sel, // Special register being addressed now
  output logic o_sfr_wr, // Special register write strobe
  output logic [3:0] o_sfr_waddr, // Special register write address
  output logic [7:0] o_sfr_wdata, // Special register write data
  output logic o_accum_wr, // Accumulator write strobe
  output logic [7:0] o_accum_wdata // Accumulator write data
);
  logic [7:0] file_select_pointer;
  logic [7:0] bank_mem [0:BDM_BANK_CNT*BDM_BANK_REGS-1];
  logic [7:0] glob_mem [0:BDM_GLOBAL_SLOTS-1];
  logic acc_global;
  logic [7:0] acc_index;
  logic acc_null;
  bdm_mode_t acc_mode;
  bdm_target_t target;
  logic [1:0] port_slot;
  logic [7:0] cur_val;
  logic [7:0] bit_mask;
  logic [7:0] next_wdata;
  logic do_write;

  bdm_addr_gen u_addr_gen (
    .i_reg_select_field(i_reg_select_field),
    .i_file_select_pointer(file_select_pointer),
    .o_global(acc_global),
    .o_index(acc_index),
    .o_null(acc_null),
    .o_mode(acc_mode)
  );

  assign port_slot = 2'(acc_index - BDM_GADDR_PORT_FIRST);

  always_comb
  begin
    if (acc_null)
      target = BDM_TGT_NONE;
    else if (!acc_global)
      target = BDM_TGT_BANK;
    else if (acc_index == BDM_GADDR_TICK && !i_option_extension_config_word_a && !i_counter_vs_accum_map)
      target = BDM_TGT_ACCUM;
    else if (acc_index == BDM_GADDR_FSR)
      target = BDM_TGT_FSR;
    else if (acc_index >= BDM_GADDR_PORT_FIRST && acc_index <= BDM_GADDR_PORT_LAST)
      target = PORT_PRESENT[port_slot] ? BDM_TGT_SFR : BDM_TGT_GLOB;
    else if (acc_index <= BDM_GADDR_SFR_LAST)
      target = BDM_TGT_SFR;
    else
      target = BDM_TGT_GLOB;
  end

  always_comb
  begin
    unique case (target)
      BDM_TGT_BANK: cur_val = bank_mem[acc_index];
      BDM_TGT_GLOB: cur_val = glob_mem[acc_index[3:0]];
      BDM_TGT_FSR: cur_val = file_select_pointer;
      BDM_TGT_SFR: cur_val = i_sfr_rdata;
      BDM_TGT_ACCUM: cur_val = i_accum;
      default: cur_val = BDM_READ_NONE;
    endcase
  end

  // A single-bit write modifies the current contents of the addressed register.
  assign bit_mask = 8'(8'h01 << i_bit_idx);
  assign next_wdata = i_bit_en ? (i_bit_val ? (cur_val | bit_mask) : (cur_val & ~bit_mask)) : i_wr_data;
  assign do_write = i_wr_en | i_bit_en;
  assign o_sfr_sel = acc_index[3:0];
  assign o_file_select_pointer = file_select_pointer;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      file_select_pointer <= BDM_FSR_RESET;
    else if (do_write && target == BDM_TGT_FSR)
      file_select_pointer <= next_wdata;
    else if (i_bank_sel_en)
      file_select_pointer <= {i_bank_sel_bits, 1'b0, file_select_pointer[3:0]};
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int i = 0; i < BDM_BANK_CNT*BDM_BANK_REGS; i++)
        bank_mem[i] <= BDM_MEM_RESET;
    end
    else if (do_write && target == BDM_TGT_BANK)
      bank_mem[acc_index] <= next_wdata;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int i = 0; i < BDM_GLOBAL_SLOTS; i++)
        glob_mem[i] <= BDM_MEM_RESET;
    end
    else if (do_write && target == BDM_TGT_GLOB)
      glob_mem[acc_index[3:0]] <= next_wdata;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rd_data <= BDM_READ_NONE;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en)
        o_rd_data <= cur_val;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_sfr_wr <= 1'b0;
      o_sfr_waddr <= 4'h0;
      o_sfr_wdata <= BDM_MEM_RESET;
      o_accum_wr <= 1'b0;
      o_accum_wdata <= BDM_MEM_RESET;
    end
    else
    begin
      o_sfr_wr <= do_write && target == BDM_TGT_SFR;
      o_accum_wr <= do_write && target == BDM_TGT_ACCUM;
      if (do_write)
      begin
        o_sfr_waddr <= acc_index[3:0];
        o_sfr_wdata <= next_wdata;
        o_accum_wdata <= next_wdata;
      end
    end
  end

  sequence s_rd_req;
    i_rd_en;
  endsequence
  sequence s_rd_done;
    ##1 o_rd_valid;
  endsequence

  property p_fsr_hold;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      !i_bank_sel_en && !(do_write && acc_global && acc_index == BDM_GADDR_FSR && !acc_null)
      |=> $stable(file_select_pointer);
  endproperty
  a_fsr_hold: assert property (p_fsr_hold) else $error("pointer changed without a write");

  property p_bank_sel;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_bank_sel_en && !do_write
      |=> file_select_pointer == {$past(i_bank_sel_bits), 1'b0, $past(file_select_pointer[3:0])};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank select update wrong");

  property p_direct;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_reg_select_field != 5'h00 && i_reg_select_field <= 5'h0F)
      |-> acc_global && acc_index == {3'h0, i_reg_select_field};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");

  property p_semi;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_reg_select_field[4] |-> !acc_global && acc_index == {file_select_pointer[7:4], i_reg_select_field[3:0]};
  endproperty
  a_semi: assert property (p_semi) else $error("semi-direct address wrong");

  property p_indirect;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_reg_select_field == 5'h00 && file_select_pointer != 8'h00
      |-> acc_index == file_select_pointer && acc_global == (file_select_pointer < 8'h10);
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect address wrong");

  property p_null_read;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_rd_en && i_reg_select_field == 5'h00 && file_select_pointer == 8'h00 |=> o_rd_data == 8'h00;
  endproperty
  a_null_read: assert property (p_null_read) else $error("zero pointer read not zero");

  property p_fsr_write;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_wr_en && i_reg_select_field == 5'h04 |=> file_select_pointer == $past(i_wr_data);
  endproperty
  a_fsr_write: assert property (p_fsr_write) else $error("pointer write lost");

  property p_accum_map;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_wr_en && i_reg_select_field == 5'h01
      |=> o_accum_wr == $past(!i_option_extension_config_word_a && !i_counter_vs_accum_map) && o_sfr_wr != o_accum_wr;
  endproperty
  a_accum_map: assert property (p_accum_map) else $error("accumulator mapping wrong");

  property p_rd_valid;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      s_rd_req |-> s_rd_done;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");
endmodule // bdm_regfile
`default_nettype wire

// >>> bdm_pkg.sv
// Constants, types and decode helpers for the banked data memory.
`default_nettype none
package bdm_pkg;
  localparam int BDM_DATA_W = 8;
  localparam int BDM_SEL_W = 5;
  localparam int BDM_BANK_CNT = 16;
  localparam int BDM_BANK_REGS = 16;
  localparam int BDM_GLOBAL_REGS = 15;
  localparam int BDM_GLOBAL_SLOTS = 16;
  localparam logic [4:0] BDM_SEL_INDIRECT = 5'h00;
  localparam logic [4:0] BDM_SEL_DIRECT_LAST = 5'h0F;
  localparam logic [7:0] BDM_GADDR_WINDOW = 8'h00;
  localparam logic [7:0] BDM_GADDR_TICK = 8'h01;
  localparam logic [7:0] BDM_GADDR_FSR = 8'h04;
  localparam logic [7:0] BDM_GADDR_PORT_FIRST = 8'h07;
  localparam logic [7:0] BDM_GADDR_PORT_LAST = 8'h09;
  localparam logic [7:0] BDM_GADDR_SFR_LAST = 8'h09;
  localparam logic [7:0] BDM_FSR_RESET = 8'h00;
  localparam logic [7:0] BDM_MEM_RESET = 8'h00;
  localparam logic [7:0] BDM_READ_NONE = 8'h00;
  localparam int BDM_FSR_CLR_BIT = 4;
  localparam logic [2:0] BDM_PORT_PRESENT_DEF = 3'h7;

  typedef enum logic [1:0] {BDM_MODE_INDIRECT, BDM_MODE_DIRECT, BDM_MODE_SEMI} bdm_mode_t;
  typedef enum logic [2:0] {BDM_TGT_NONE, BDM_TGT_BANK, BDM_TGT_GLOB, BDM_TGT_FSR, BDM_TGT_SFR,
                            BDM_TGT_ACCUM} bdm_target_t;

  // Addressing mode carried by a register select field.
  function automatic bdm_mode_t bdm_mode_of(input logic [4:0] sel);
    if (sel == BDM_SEL_INDIRECT)
      return BDM_MODE_INDIRECT;
    else if (sel <= BDM_SEL_DIRECT_LAST)
      return BDM_MODE_DIRECT;
    else
      return BDM_MODE_SEMI;
  endfunction
endpackage
`default_nettype wire

// >>> bdm_addr_gen.sv
// Address generator: turns a register select field and the pointer into a target.
`timescale 1ns/1ps
`default_nettype none
module bdm_addr_gen
  import bdm_pkg::*;
(
  input wire logic [4:0] i_reg_select_field, // Select field of the instruction
  input wire logic [7:0] i_file_select_pointer, // Current pointer value
  output logic o_global, // Target lies in the global bank
  output logic [7:0] o_index, // Global address or {bank, register}
  output logic o_null, // Indirect access through a zero pointer
  output bdm_mode_t o_mode // Decoded addressing mode
);
  always_comb
  begin
    o_mode = bdm_mode_of(i_reg_select_field);
    o_null = 1'b0;
    unique case (o_mode)
      BDM_MODE_INDIRECT:
      begin
        o_index = i_file_select_pointer;
        o_global = (i_file_select_pointer[7:4] == 4'h0);
        o_null = (i_file_select_pointer == BDM_GADDR_WINDOW);
      end
      BDM_MODE_DIRECT:
      begin
        o_index = {3'h0, i_reg_select_field};
        o_global = 1'b1;
      end
      BDM_MODE_SEMI:
      begin
        o_index = {i_file_select_pointer[7:4], i_reg_select_field[3:0]};
        o_global = 1'b0;
      end
      default:
      begin
        o_index = BDM_GADDR_WINDOW;
        o_global = 1'b1;
      end
    endcase
  end
endmodule // bdm_addr_gen
`default_nettype wire

// >>> bdm_cpu_model.sv
// Model of the instruction datapath: special registers and accumulator.
`timescale 1ns/1ps
`default_nettype none
module bdm_cpu_model
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_arst_n, // Reset, active low
  input wire logic [3:0] i_sfr_sel, // Special register addressed
  input wire logic i_sfr_wr, // Special register write
  input wire logic [3:0] i_sfr_waddr, // Write address
  input wire logic [7:0] i_sfr_wdata, // Write data
  input wire logic i_accum_wr, // Accumulator write
  input wire logic [7:0] i_accum_wdata, // Accumulator write data
  output logic [7:0] o_accum, // Accumulator value
  output logic [7:0] o_sfr_rdata // Special register contents
);
  logic [7:0] sfr [16];
  // Special registers start apart from the accumulator so a wrong source shows.
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
    if (!i_arst_n)
    begin
      for (int k = 0; k < 16; k++)
        sfr[k] <= 8'h3C;
      o_accum <= 8'hA5;
    end
    else
    begin
      if (i_sfr_wr)
        sfr[i_sfr_waddr] <= i_sfr_wdata;
      if (i_accum_wr)
        o_accum <= i_accum_wdata;
    end
  assign o_sfr_rdata = sfr[i_sfr_sel];
endmodule // bdm_cpu_model
`default_nettype wire

// >>> banked_data_memory_addressing_tb.sv
// Self-checking bench for the banked data memory.
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_addressing_tb;
  import bdm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0, bit_en = 1'b0, bit_val = 1'b0;
  logic bs_en = 1'b0, config_word_a = 1'b1, amap = 1'b1;
  logic [4:0] sel = 5'h00;
  logic [2:0] bit_idx = 3'h0, bs_bits = 3'h0;
  logic [7:0] wdata = 8'h00, accum, sfr_rdata, rdata, ptr, sfr_wdata, acc_wdata;
  logic rvalid, sfr_wr, acc_wr;
  logic [3:0] sfr_sel, sfr_waddr;
  logic [7:0] np_rdata;
  logic np_sfr_wr;
  int err_total = 0, check_count = 0, cyc = 0;
  bdm_regfile uut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_reg_select_field(sel), .i_rd_en(rd_en), .i_wr_en(wr_en),
    .i_wr_data(wdata), .i_bit_en(bit_en), .i_bit_idx(bit_idx), .i_bit_val(bit_val), .i_bank_sel_en(bs_en),
    .i_bank_sel_bits(bs_bits), .i_option_extension_config_word_a(config_word_a), .i_counter_vs_accum_map(amap), .i_accum(accum),
    .i_sfr_rdata(sfr_rdata), .o_rd_data(rdata), .o_rd_valid(rvalid), .o_file_select_pointer(ptr),
    .o_sfr_sel(sfr_sel), .o_sfr_wr(sfr_wr), .o_sfr_waddr(sfr_waddr), .o_sfr_wdata(sfr_wdata),
    .o_accum_wr(acc_wr), .o_accum_wdata(acc_wdata));
  bdm_cpu_model cpu (.i_clk_sys(clk), .i_arst_n(rst_n), .i_sfr_sel(sfr_sel), .i_sfr_wr(sfr_wr),
    .i_sfr_waddr(sfr_waddr), .i_sfr_wdata(sfr_wdata), .i_accum_wr(acc_wr), .i_accum_wdata(acc_wdata),
    .o_accum(accum), .o_sfr_rdata(sfr_rdata));
  // Second copy built without the port at 07h; its special-register read data is a marker value.
  bdm_regfile #(.PORT_PRESENT(3'h6)) uut_np (.i_clk_sys(clk), .i_arst_n(rst_n), .i_reg_select_field(sel),
    .i_rd_en(rd_en), .i_wr_en(wr_en), .i_wr_data(wdata), .i_bit_en(bit_en), .i_bit_idx(bit_idx),
    .i_bit_val(bit_val), .i_bank_sel_en(bs_en), .i_bank_sel_bits(bs_bits), .i_option_extension_config_word_a(config_word_a),
    .i_counter_vs_accum_map(amap), .i_accum(accum), .i_sfr_rdata(8'hC3), .o_rd_data(np_rdata),
    .o_rd_valid(), .o_file_select_pointer(), .o_sfr_sel(), .o_sfr_wr(np_sfr_wr), .o_sfr_waddr(),
    .o_sfr_wdata(), .o_accum_wr(), .o_accum_wdata());
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic print_verdict;
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("BAD %0t data %h expected %h", $time, g, e);
      err_total++;
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e)
    begin
      $display("BAD %0t flag %b expected %b", $time, g, e);
      err_total++;
    end
  endtask
  task automatic wr(input logic [4:0] s, input logic [7:0] d);
    @(negedge clk);
    sel = s;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [4:0] s, input logic [7:0] e);
    @(negedge clk);
    sel = s;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    chk1(rvalid, 1'b1);
    chk(rdata, e);
  endtask
  task automatic bw(input logic [4:0] s, input logic [2:0] idx, input logic v);
    @(negedge clk);
    sel = s;
    bit_idx = idx;
    bit_val = v;
    bit_en = 1'b1;
    @(negedge clk);
    bit_en = 1'b0;
  endtask
  task automatic bs(input logic [2:0] b);
    @(negedge clk);
    bs_bits = b;
    bs_en = 1'b1;
    @(negedge clk);
    bs_en = 1'b0;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk(ptr, 8'h00);
    wr(5'h04, 8'hF0);
    chk(ptr, 8'hF0);
    wr(5'h1F, 8'h55);
    rd(5'h1F, 8'h55);
    wr(5'h04, 8'hFF);
    rd(5'h00, 8'h55);
    rd(5'h1F, 8'h55);
    wr(5'h04, 8'h05);
    wr(5'h13, 8'hAA);
    rd(5'h13, 8'hAA);
    wr(5'h04, 8'h13);
    rd(5'h00, 8'h00);
    wr(5'h04, 8'h03);
    rd(5'h00, 8'h3C);
    for (int i = 10; i < 16; i++)
      wr(5'(i), 8'(i) + 8'h40);
    wr(5'h04, 8'h00);
    wr(5'h1A, 8'h77);
    rd(5'h0A, 8'h4A);
    rd(5'h1A, 8'h77);
    wr(5'h00, 8'h12);
    rd(5'h00, 8'h00);
    rd(5'h1A, 8'h77);
    wr(5'h04, 8'h0B);
    rd(5'h00, 8'h4B);
    wr(5'h00, 8'h99);
    rd(5'h0B, 8'h99);
    wr(5'h04, 8'h1F);
    bs(3'h1);
    chk(ptr, 8'h2F);
    bw(5'h04, 3'h4, 1'b1);
    chk(ptr, 8'h3F);
    wr(5'h1F, 8'h66);
    rd(5'h00, 8'h66);
    bw(5'h04, 3'h4, 1'b0);
    chk(ptr, 8'h2F);
    rd(5'h0F, 8'h4F);
    wr(5'h07, 8'h21);
    chk1(sfr_wr, 1'b1);
    chk1(np_sfr_wr, 1'b0);
    rd(5'h07, 8'h21);
    chk(np_rdata, 8'h21);
    rd(5'h01, 8'h3C);
    config_word_a = 1'b0;
    amap = 1'b0;
    rd(5'h01, 8'hA5);
    wr(5'h01, 8'h5A);
    chk1(acc_wr, 1'b1);
    rd(5'h01, 8'h5A);
    config_word_a = 1'b1;
    rd(5'h01, 8'h3C);
    print_verdict;
  end
endmodule // banked_data_memory_addressing_tb
`default_nettype wire
